// [rtl/bt_consts.svh]
`ifndef BT_CONSTS_SVH
`define BT_CONSTS_SVH

// ------------------------------------------------------------
// Word geometry
// ------------------------------------------------------------
`define BT_WORD_W      16
`define BT_BIT_W       4
`define BT_ADDR_W      8
`define BT_TC_MAX      8'h7F
`define BT_MEM_DEPTH   1024

// ------------------------------------------------------------
// Timer and counter word fields
// ------------------------------------------------------------
`define BT_VALUE_LSB   0
`define BT_VALUE_MSB   9
`define BT_TBASE_LSB   12
`define BT_TBASE_MSB   13

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define BT_RLO_RST     1'h0

`endif

// [rtl/bt_ops.sv]
// Summary of operation
// - Enable acts only on a zero-to-one transition of the logic result bit.
// - Enable event restarts timer, presets or counts, if start sees one.
// - Enable lets start, set and count act without a new start edge.
// - Enable addresses timers and counters 0 to 127 only.
// - Test-one reads bit ignoring result, then result equals bit.
// - Test-zero reads bit ignoring result, then result is inverted bit.
// - Force-high writes one into bit, result bit unchanged.
// - Force-low writes zero into bit, result bit unchanged.
// - System data bits 0.0 to 255.15 allowed for tests, refused otherwise.
// - Timer or counter value in bits 0 to 9, time base in 12-13.
`include "bt_consts.svh"

module bt_ops (
    // Clock and reset
    input  wire logic                      I_CLOCK,
    input  wire logic                      I_RST_N,
    // Operation request
    input  wire logic                      I_EXEC,
    input  wire logic [2:0]                I_OPCODE,
    input  wire logic [1:0]                I_AREA,
    input  wire logic [`BT_ADDR_W-1:0]     I_WORD,
    input  wire logic [`BT_BIT_W-1:0]      I_BIT,
    input  wire logic                      I_START_RLO,
    // Logic result load from other operations
    input  wire logic                      I_RLO_WR,
    input  wire logic                      I_RLO_IN,
    // Word write port
    input  wire logic                      I_WR_EN,
    input  wire logic [1:0]                I_WR_AREA,
    input  wire logic [`BT_ADDR_W-1:0]     I_WR_WORD,
    input  wire logic [`BT_WORD_W-1:0]     I_WR_DATA,
    // Word read port
    input  wire logic [1:0]                I_RD_AREA,
    input  wire logic [`BT_ADDR_W-1:0]     I_RD_WORD,
    output logic [`BT_WORD_W-1:0]          O_RD_DATA,
    output logic [9:0]                     O_RD_VALUE,
    output logic [1:0]                     O_RD_TBASE,
    // Status
    output logic                           O_RLO,
    output logic                           O_DONE,
    output logic                           O_REJECT,
    // Retrigger request to timer and counter cores
    output logic                           O_RETRIG,
    output logic                           O_RETRIG_CNT,
    output logic [6:0]                     O_RETRIG_NUM
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [`BT_WORD_W-1:0] mem [0:`BT_MEM_DEPTH-1];
    logic [127:0]          edge_tmr;
    logic [127:0]          edge_cnt;
    logic                  logic_result_bit;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic is_tc(input logic [1:0] area);
        is_tc = (area == bt_pkg::BT_AREA_TIMER) ||
                (area == bt_pkg::BT_AREA_COUNTER);
    endfunction : is_tc

    wire [9:0]  op_idx    = {I_AREA, I_WORD};
    wire [15:0] op_word   = mem[op_idx];
    wire        sel_bit   = op_word[I_BIT];
    wire        tc_range  = I_WORD <= `BT_TC_MAX;
    wire        is_en     = I_OPCODE == bt_pkg::BT_OP_RETRIGGER_ENABLE;
    wire        is_t1     = I_OPCODE == bt_pkg::BT_OP_TEST_BIT_ONE;
    wire        is_t0     = I_OPCODE == bt_pkg::BT_OP_TEST_BIT_ZERO;
    wire        is_fh     = I_OPCODE == bt_pkg::BT_OP_FORCE_BIT_HIGH;
    wire        is_fl     = I_OPCODE == bt_pkg::BT_OP_FORCE_BIT_LOW;
    wire        sys_area  = I_AREA == bt_pkg::BT_AREA_SYSTEM;
    wire        range_ok  = !is_tc(I_AREA) || tc_range;
    wire        legal     = (is_en && is_tc(I_AREA) && tc_range)
                          || ((is_t1 || is_t0) && range_ok)
                          || ((is_fh || is_fl) && range_ok
                              && !sys_area);
    wire        go        = I_EXEC && legal;
    wire        tc_cnt    = I_AREA == bt_pkg::BT_AREA_COUNTER;
    wire [6:0]  tc_num    = I_WORD[6:0];
    wire        prev_edge = tc_cnt ? edge_cnt[tc_num] : edge_tmr[tc_num];
    wire        rise      = logic_result_bit && !prev_edge;
    wire        next_retrig = go && is_en && rise && I_START_RLO;
    wire        next_rlo  = (go && is_t1) ? sel_bit :
                            (go && is_t0) ? !sel_bit :
                            I_RLO_WR      ? I_RLO_IN : logic_result_bit;
    wire [15:0] bit_mask  = 16'h0001 << I_BIT;
    wire        do_force  = go && (is_fh || is_fl);
    wire [15:0] force_val = is_fh ? (op_word | bit_mask)
                                  : (op_word & ~bit_mask);
    wire [9:0]  rd_idx    = {I_RD_AREA, I_RD_WORD};
    wire [15:0] rd_word   = mem[rd_idx];
    wire [9:0]  wr_idx    = {I_WR_AREA, I_WR_WORD};
    wire [1:0]  wr_tbase  = I_WR_DATA[`BT_TBASE_MSB:`BT_TBASE_LSB];
    wire [9:0]  wr_value  = I_WR_DATA[`BT_VALUE_MSB:`BT_VALUE_LSB];

    // ------------------------------------------------------------
    // Word memory
    // ------------------------------------------------------------
    always_ff @(posedge I_CLOCK) begin
        if (do_force) begin
            mem[op_idx] <= force_val;
        end else if (I_WR_EN) begin
            mem[wr_idx] <= I_WR_DATA;
        end
    end

    // ------------------------------------------------------------
    // Edge memory per timer and counter
    // ------------------------------------------------------------
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            edge_tmr <= 128'h0;
            edge_cnt <= 128'h0;
        end else if (go && is_en && tc_cnt) begin
            edge_cnt[tc_num] <= logic_result_bit;
        end else if (go && is_en) begin
            edge_tmr[tc_num] <= logic_result_bit;
        end
    end

    // ------------------------------------------------------------
    // Result bit and outputs
    // ------------------------------------------------------------
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            logic_result_bit          <= `BT_RLO_RST;
            O_DONE       <= 1'h0;
            O_REJECT     <= 1'h0;
            O_RETRIG     <= 1'h0;
            O_RETRIG_CNT <= 1'h0;
            O_RETRIG_NUM <= 7'h00;
        end else begin
            logic_result_bit          <= next_rlo;
            O_DONE       <= go;
            O_REJECT     <= I_EXEC && !legal;
            O_RETRIG     <= next_retrig;
            O_RETRIG_CNT <= tc_cnt;
            O_RETRIG_NUM <= tc_num;
        end
    end

    assign O_RLO = logic_result_bit;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            O_RD_DATA  <= 16'h0000;
            O_RD_VALUE <= 10'h000;
            O_RD_TBASE <= 2'h0;
        end else begin
            O_RD_DATA  <= rd_word;
            O_RD_VALUE <= rd_word[`BT_VALUE_MSB:`BT_VALUE_LSB];
            O_RD_TBASE <= rd_word[`BT_TBASE_MSB:`BT_TBASE_LSB];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_retrig_rise: assert property (@(posedge I_CLOCK)
        disable iff (!I_RST_N)
        O_RETRIG |-> $past(logic_result_bit) && !$past(prev_edge))
        else $error("retrigger without rising result");
    a_retrig_idle: assert property (@(posedge I_CLOCK)
        disable iff (!I_RST_N)
        !(go && is_en) |=> !O_RETRIG)
        else $error("retrigger without enable");
    a_retrig_start: assert property (@(posedge I_CLOCK)
        disable iff (!I_RST_N)
        O_RETRIG |-> $past(I_START_RLO) && $past(is_en))
        else $error("retrigger without start result one");
    a_retrig_any_edge: assert property (@(posedge I_CLOCK)
        disable iff (!I_RST_N)
        (I_EXEC && is_en && legal && logic_result_bit && !prev_edge && I_START_RLO)
        |=> O_RETRIG && O_RETRIG_NUM == $past(tc_num)
        && O_RETRIG_CNT == $past(tc_cnt))
        else $error("enable event dropped");
    a_retrig_range: assert property (@(posedge I_CLOCK)
        disable iff (!I_RST_N)
        (I_EXEC && is_en && !tc_range) |=> !O_RETRIG && O_REJECT)
        else $error("out of range enable accepted");
    a_reject_quiet: assert property (@(posedge I_CLOCK)
        disable iff (!I_RST_N)
        (I_EXEC && !legal && !I_RLO_WR) |=> O_REJECT && !O_DONE
        && !O_RETRIG && logic_result_bit == $past(logic_result_bit))
        else $error("refused operation had an effect");
    a_test_one: assert property (@(posedge I_CLOCK)
        disable iff (!I_RST_N)
        (go && is_t1) |=> logic_result_bit == $past(sel_bit))
        else $error("test one result wrong");
    a_test_zero: assert property (@(posedge I_CLOCK)
        disable iff (!I_RST_N)
        (go && is_t0) |=> logic_result_bit != $past(sel_bit))
        else $error("test zero result wrong");
    a_force_high: assert property (@(posedge I_CLOCK)
        disable iff (!I_RST_N)
        (go && is_fh && !I_RLO_WR) |=> logic_result_bit == $past(logic_result_bit)
        && mem[$past(op_idx)][$past(I_BIT)])
        else $error("force high wrong");
    a_force_low: assert property (@(posedge I_CLOCK)
        disable iff (!I_RST_N)
        (go && is_fl && !I_RLO_WR) |=> logic_result_bit == $past(logic_result_bit)
        && !mem[$past(op_idx)][$past(I_BIT)])
        else $error("force low wrong");
    a_system_refuse: assert property (@(posedge I_CLOCK)
        disable iff (!I_RST_N)
        (I_EXEC && sys_area && (is_fh || is_fl)) |=> O_REJECT && !O_DONE)
        else $error("system area write accepted");
    a_steady_rlo: assert property (@(posedge I_CLOCK)
        disable iff (!I_RST_N)
        (go && is_en && logic_result_bit == prev_edge) |=> !O_RETRIG)
        else $error("steady result retriggered");
    a_tbase_field: assert property (@(posedge I_CLOCK)
        disable iff (!I_RST_N)
        (I_WR_EN && !do_force && wr_idx == rd_idx)
        ##1 (rd_idx == $past(rd_idx))
        |=> O_RD_TBASE == $past(wr_tbase, 2))
        else $error("time base field wrong");
    a_value_field: assert property (@(posedge I_CLOCK)
        disable iff (!I_RST_N)
        (I_WR_EN && !do_force && wr_idx == rd_idx)
        ##1 (rd_idx == $past(rd_idx))
        |=> O_RD_VALUE == $past(wr_value, 2))
        else $error("value field wrong");

endmodule : bt_ops

// [rtl/bt_pkg.sv]
package bt_pkg;

    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BT_OP_RETRIGGER_ENABLE = 3'h0,
        BT_OP_TEST_BIT_ONE     = 3'h1,
        BT_OP_TEST_BIT_ZERO    = 3'h2,
        BT_OP_FORCE_BIT_HIGH   = 3'h3,
        BT_OP_FORCE_BIT_LOW    = 3'h4
    } bt_op_t;

    // ------------------------------------------------------------
    // Operand areas
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BT_AREA_TIMER   = 2'h0,
        BT_AREA_COUNTER = 2'h1,
        BT_AREA_DATA    = 2'h2,
        BT_AREA_SYSTEM  = 2'h3
    } bt_area_t;

endpackage : bt_pkg

// [verification/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    localparam logic [2:0] EN = bt_pkg::BT_OP_RETRIGGER_ENABLE;
    localparam logic [2:0] T1 = bt_pkg::BT_OP_TEST_BIT_ONE;
    localparam logic [2:0] T0 = bt_pkg::BT_OP_TEST_BIT_ZERO;
    localparam logic [2:0] FH = bt_pkg::BT_OP_FORCE_BIT_HIGH;
    localparam logic [2:0] FL = bt_pkg::BT_OP_FORCE_BIT_LOW;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        exec = 1'h0;
    logic        st = 1'h0;
    logic        rwr = 1'h0;
    logic        rin = 1'h0;
    logic        wen = 1'h0;
    logic [2:0]  opc = 3'h0;
    logic [1:0]  ar = 2'h0;
    logic [1:0]  war = 2'h0;
    logic [1:0]  rar = 2'h0;
    logic [7:0]  wd = 8'h00;
    logic [7:0]  wwd = 8'h00;
    logic [7:0]  rwd = 8'h00;
    logic [3:0]  bn = 4'h0;
    logic [15:0] wdat = 16'h0000;
    wire logic [15:0] rdat;
    wire logic [9:0]  rval;
    wire logic [1:0]  rtb;
    wire logic        logic_result_bit, done, rej, rt, rtc;
    wire logic [6:0]  rtn;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;

    bt_ops u_bt_ops (.I_CLOCK(clk), .I_RST_N(rst_n), .I_EXEC(exec),
        .I_OPCODE(opc), .I_AREA(ar), .I_WORD(wd), .I_BIT(bn),
        .I_START_RLO(st), .I_RLO_WR(rwr), .I_RLO_IN(rin), .I_WR_EN(wen),
        .I_WR_AREA(war), .I_WR_WORD(wwd), .I_WR_DATA(wdat),
        .I_RD_AREA(rar), .I_RD_WORD(rwd), .O_RD_DATA(rdat),
        .O_RD_VALUE(rval), .O_RD_TBASE(rtb), .O_RLO(logic_result_bit), .O_DONE(done),
        .O_REJECT(rej), .O_RETRIG(rt), .O_RETRIG_CNT(rtc),
        .O_RETRIG_NUM(rtn));

    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            results();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk_flag(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t flag got %b exp %b", $time, g, e);
        end
    endtask : chk_flag
    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t word got %h exp %h", $time, g, e);
        end
    endtask : chk_word
    task automatic op(input logic [2:0] o, input logic [1:0] a,
                      input logic [7:0] w, input logic [3:0] b,
                      input logic s, input logic rj);
        @(posedge clk);
        exec <= 1'h1;
        opc <= o;
        ar <= a;
        wd <= w;
        bn <= b;
        st <= s;
        @(posedge clk);
        exec <= 1'h0;
        #1;
        chk_flag(done, ~rj);
        chk_flag(rej, rj);
    endtask : op
    task automatic set_rlo(input logic v);
        @(posedge clk);
        rwr <= 1'h1;
        rin <= v;
        @(posedge clk);
        rwr <= 1'h0;
        #1;
        chk_flag(logic_result_bit, v);
    endtask : set_rlo
    task automatic wr(input logic [1:0] a, input logic [7:0] w,
                      input logic [15:0] d);
        @(posedge clk);
        wen <= 1'h1;
        war <= a;
        wwd <= w;
        wdat <= d;
        @(posedge clk);
        wen <= 1'h0;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] w,
                      input logic [15:0] e);
        @(posedge clk);
        rar <= a;
        rwd <= w;
        @(posedge clk);
        #1;
        chk_word(rdat, e);
    endtask : rd
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_test;
        wr(2'h2, 8'h05, 16'h0008);
        wr(2'h3, 8'hFF, 16'h8000);
        set_rlo(1'h0);
        op(T1, 2'h2, 8'h05, 4'h3, 1'h0, 1'h0);
        chk_flag(logic_result_bit, 1'h1);
        op(T0, 2'h2, 8'h05, 4'h3, 1'h0, 1'h0);
        chk_flag(logic_result_bit, 1'h0);
        op(T1, 2'h3, 8'hFF, 4'hF, 1'h0, 1'h0);
        chk_flag(logic_result_bit, 1'h1);
    endtask : t_test
    task automatic t_force;
        op(FH, 2'h2, 8'h05, 4'h0, 1'h0, 1'h0);
        chk_flag(logic_result_bit, 1'h1);
        rd(2'h2, 8'h05, 16'h0009);
        op(FL, 2'h2, 8'h05, 4'h3, 1'h0, 1'h0);
        chk_flag(logic_result_bit, 1'h1);
        rd(2'h2, 8'h05, 16'h0001);
        op(FL, 2'h3, 8'hFF, 4'hF, 1'h0, 1'h1);
        rd(2'h3, 8'hFF, 16'h8000);
    endtask : t_force
    task automatic t_enable;
        op(EN, 2'h0, 8'h7F, 4'h0, 1'h1, 1'h0);
        chk_flag(rt, 1'h1);
        chk_flag(rtc, 1'h0);
        chk_word({9'h0, rtn}, 16'h007F);
        op(EN, 2'h0, 8'h7F, 4'h0, 1'h1, 1'h0);
        chk_flag(rt, 1'h0);
        op(EN, 2'h1, 8'h05, 4'h0, 1'h0, 1'h0);
        chk_flag(rt, 1'h0);
        set_rlo(1'h0);
        op(EN, 2'h1, 8'h05, 4'h0, 1'h1, 1'h0);
        chk_flag(rt, 1'h0);
        set_rlo(1'h1);
        op(EN, 2'h1, 8'h05, 4'h0, 1'h1, 1'h0);
        chk_flag(rt, 1'h1);
        chk_flag(rtc, 1'h1);
        chk_word({9'h0, rtn}, 16'h0005);
        op(EN, 2'h0, 8'h80, 4'h0, 1'h1, 1'h1);
        op(EN, 2'h2, 8'h05, 4'h0, 1'h1, 1'h1);
        chk_flag(rt, 1'h0);
    endtask : t_enable
    task automatic t_fields;
        wr(2'h0, 8'h03, 16'h2155);
        rd(2'h0, 8'h03, 16'h2155);
        chk_word({6'h0, rval}, 16'h0155);
        chk_word({14'h0, rtb}, 16'h0002);
        wr(2'h0, 8'h03, 16'h13AA);
        rd(2'h0, 8'h03, 16'h13AA);
        chk_word({6'h0, rval}, 16'h03AA);
        chk_word({14'h0, rtb}, 16'h0001);
    endtask : t_fields
    task automatic results;
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        #1;
        chk_flag(logic_result_bit, 1'h0);
        t_test();
        t_force();
        t_enable();
        t_fields();
        results();
    end
endmodule : testbench
